// ==== hw/aperture_delay_pkg.sv ====
package aperture_delay_pkg;
    // ========================================
    // register indices (byte address = index * 4)
    localparam int ADDR_W = 14;
    localparam logic [11:0] IDX_CAL_ENABLE = 12'h2B0;
    localparam logic [11:0] IDX_CAL_CONFIG = 12'h2B1;
    localparam logic [11:0] IDX_CAL_STATUS = 12'h2B2;
    localparam logic [11:0] IDX_DELAY_ADJUST = 12'h2B5;
    localparam logic [11:0] IDX_RAMP_CONTROL = 12'h2B8;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h2C8;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h2C9;

    // ========================================
    // fields and reset values
    localparam int CAL_DONE_BIT = 17;
    localparam int CLOCK_INVERT_BIT = 16;
    localparam int COARSE_LSB = 8;
    localparam int RAMP_EN_BIT = 0;
    localparam int RAMP_RATE_BIT = 1;
    localparam int CFG_AVG_LSB = 2;
    localparam int IRQ_CAL_DONE = 0;
    localparam int IRQ_RAMP_DONE = 1;
    localparam logic [7:0] CAL_CONFIG_RESET = 8'h05;
    localparam logic [23:0] DELAY_ADJUST_RESET = 24'h000000;
    localparam logic [7:0] RAMP_CONTROL_RESET = 8'h00;
    localparam logic [7:0] COARSE_STEP_SLOW = 8'h01;
    localparam logic [7:0] COARSE_STEP_FAST = 8'h04;
    localparam logic [7:0] RAMP_PRESCALE_LAST = 8'hFF;
    localparam int CAL_UNIT_CYCLES = 256 * 19 * 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================
    // types
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_DONE = 2'b10
    } cal_state_t;

    typedef struct packed {
        logic aw_got;
        logic [11:0] aw_idx;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] cal_enable;
        logic [7:0] cal_config;
        cal_state_t cal_state;
        logic [19:0] cal_cnt;
        logic [16:0] cal_result;
        logic [23:0] delay_adjust;
        logic [7:0] ramp_control;
        logic [7:0] coarse_out;
        logic ramp_fast;
        logic ramp_active;
        logic [7:0] prescale;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic irq;
        logic [16:0] tad;
    } state_t;
endpackage

// ==== hw/aperture_delay_control.sv ====
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module aperture_delay_control
    import aperture_delay_pkg::*;
#(
    parameter int CAL_UNIT = CAL_UNIT_CYCLES
) (
    input wire logic aclk, // device clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [16:0] cal_measured_delay, // delay found by the timing search
    output logic [16:0] tad_delay, // applied aperture delay code
    output logic clock_invert, // invert sampling_clock
    output logic irq // level interrupt
);

    state_t q, d;
    logic aw_hs, w_hs, ar_hs;
    logic [11:0] ar_idx;
    logic [19:0] cal_limit;
    logic [7:0] step, target, gap;
    logic [31:0] merged;

    // ========================================
    // bus handshakes
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[ADDR_W-1:2];
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign tad_delay = q.tad;
    assign irq = q.irq;

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign cal_limit = 20'(CAL_UNIT * (32'(q.cal_config[CFG_AVG_LSB +: 2])
                           + 32'(q.cal_config[1:0]) + 32'd2));
    assign step = q.ramp_fast ? COARSE_STEP_FAST : COARSE_STEP_SLOW;
    assign target = q.delay_adjust[COARSE_LSB +: 8];
    assign gap = (q.coarse_out > target) ? (q.coarse_out - target) : (target - q.coarse_out);

    // ========================================
    // next state
    always_comb begin
        d = q;
        merged = '0;

        // write channel
        if (aw_hs) begin
            d.aw_got = 1'b1;
            d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
        end
        if (w_hs) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (q.aw_idx == IDX_CAL_ENABLE) begin
                merged = lane_merge({24'h000000, q.cal_enable}, q.wdata, q.wstrb);
                d.cal_enable = merged[7:0];
            end else if (q.aw_idx == IDX_CAL_CONFIG) begin
                merged = lane_merge({24'h000000, q.cal_config}, q.wdata, q.wstrb);
                d.cal_config = merged[7:0];
            end else if (q.aw_idx == IDX_CAL_STATUS) begin
                d.bresp = RESP_OKAY;
            end else if (q.aw_idx == IDX_DELAY_ADJUST) begin
                merged = lane_merge({8'h00, q.delay_adjust}, q.wdata, q.wstrb);
                d.delay_adjust = merged[23:0];
                if (q.wstrb[1]) begin
                    d.ramp_active = q.ramp_control[RAMP_EN_BIT];
                    d.prescale = '0;
                    if (q.ramp_control[RAMP_EN_BIT]) begin
                        d.ramp_fast = q.ramp_control[RAMP_RATE_BIT];
                    end
                end
            end else if (q.aw_idx == IDX_RAMP_CONTROL) begin
                merged = lane_merge({24'h000000, q.ramp_control}, q.wdata, q.wstrb);
                d.ramp_control = merged[7:0];
            end else if (q.aw_idx == IDX_IRQ_STATUS) begin
                d.bresp = RESP_OKAY;
            end else if (q.aw_idx == IDX_IRQ_MASK) begin
                merged = lane_merge({24'h000000, 6'h00, q.irq_mask}, q.wdata, q.wstrb);
                d.irq_mask = merged[1:0];
            end else begin
                d.bresp = RESP_SLVERR;
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            if (ar_idx == IDX_CAL_ENABLE) begin
                d.rdata[7:0] = q.cal_enable;
            end else if (ar_idx == IDX_CAL_CONFIG) begin
                d.rdata[7:0] = q.cal_config;
            end else if (ar_idx == IDX_CAL_STATUS) begin
                d.rdata[CAL_DONE_BIT] = q.cal_enable[0] && (q.cal_state == CAL_DONE);
                d.rdata[16:0] = q.cal_result;
            end else if (ar_idx == IDX_DELAY_ADJUST) begin
                d.rdata[23:0] = q.delay_adjust;
            end else if (ar_idx == IDX_RAMP_CONTROL) begin
                d.rdata[7:0] = q.ramp_control;
            end else if (ar_idx == IDX_IRQ_STATUS) begin
                d.rdata[1:0] = q.irq_status;
                d.irq_status = '0;
            end else if (ar_idx == IDX_IRQ_MASK) begin
                d.rdata[1:0] = q.irq_mask;
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end

        // calibration sequence
        // launch on rising enable
        case (q.cal_state)
            CAL_IDLE: begin
                if (d.cal_enable[0] && !q.cal_enable[0]) begin
                    d.cal_state = CAL_RUN;
                    d.cal_cnt = '0;
                end
            end
            CAL_RUN: begin
                d.cal_cnt = q.cal_cnt + 20'h00001;
                if (q.cal_cnt >= cal_limit - 20'h00001) begin
                    d.cal_state = CAL_DONE;
                    d.cal_result = cal_measured_delay;
                    d.irq_status[IRQ_CAL_DONE] = 1'b1;
                end
            end
            CAL_DONE: begin
                d.cal_state = CAL_DONE;
            end
            default: begin
                d.cal_state = CAL_IDLE;
            end
        endcase
        if (!q.cal_enable[0]) begin
            d.cal_state = (d.cal_enable[0]) ? CAL_RUN : CAL_IDLE;
            d.cal_cnt = '0;
        end

        // coarse output
        if (!q.ramp_active) begin
            d.coarse_out = target;
        end else begin
            d.prescale = q.prescale + 8'h01;
            if (q.coarse_out == target) begin
                d.ramp_active = 1'b0;
                d.irq_status[IRQ_RAMP_DONE] = 1'b1;
            end else if (q.prescale == RAMP_PRESCALE_LAST) begin
                if (gap <= step) begin
                    d.coarse_out = target;
                end else if (q.coarse_out < target) begin
                    d.coarse_out = q.coarse_out + step;
                end else begin
                    d.coarse_out = q.coarse_out - step;
                end
            end
        end

        // applied delay
        if (q.cal_enable[0]) begin
            d.tad = q.cal_result;
        end else begin
            d.tad = {q.delay_adjust[CLOCK_INVERT_BIT], q.coarse_out, q.delay_adjust[7:0]};
        end

        d.irq = |(q.irq_status & q.irq_mask);
    end

    assign clock_invert = q.tad[CLOCK_INVERT_BIT];

    // ========================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.cal_config <= CAL_CONFIG_RESET;
            q.delay_adjust <= DELAY_ADJUST_RESET;
            q.ramp_control <= RAMP_CONTROL_RESET;
            q.cal_state <= CAL_IDLE;
        end else begin
            q <= d;
        end
    end

endmodule // aperture_delay_control

// ==== sim/delay_ctl_props.sv ====
`timescale 1ns/1ps
module delay_ctl_props
    import aperture_delay_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [16:0] tad_delay, // delay code
    input wire logic clock_invert // invert
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ====================
    // bus handshakes
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ar;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_inv; clock_invert == tad_delay[16]; endproperty
    a_inv: assert property (p_inv) else $error("invert differs from delay bit");
    property p_bans; s_wr |-> ##2 s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_rans; s_ar |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_arrdy; s_axi_arready == !s_axi_rvalid; endproperty
    a_arrdy: assert property (p_arrdy) else $error("arready wrong");
    property p_resv; s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00; endproperty
    a_resv: assert property (p_resv) else $error("upper read bits set");
    property p_rst;
        disable iff (1'b0) !aresetn |=> tad_delay == 17'h00000 && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // delay_ctl_props

bind aperture_delay_control delay_ctl_props u_delay_ctl_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tad_delay,
    .clock_invert);

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb
    import aperture_delay_pkg::*;
;
    typedef struct packed {logic [33:0] e; logic [33:0] m;} note_t;
    localparam logic [33:0] ALL = 34'h3FFFFFFFF;
    localparam logic [13:0] A_EN = {IDX_CAL_ENABLE, 2'b00};
    localparam logic [13:0] A_CFG = {IDX_CAL_CONFIG, 2'b00};
    localparam logic [13:0] A_ST = {IDX_CAL_STATUS, 2'b00};
    localparam logic [13:0] A_DLY = {IDX_DELAY_ADJUST, 2'b00};
    localparam logic [13:0] A_RMP = {IDX_RAMP_CONTROL, 2'b00};
    localparam logic [13:0] A_IS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [13:0] A_IM = {IDX_IRQ_MASK, 2'b00};
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [16:0] cal_measured_delay, tad_delay;
    logic clock_invert, irq;
    logic [23:0] v;
    logic [7:0] t;
    note_t q[$];
    note_t nt;
    int n_fail, cmp_count, i, n, seed;
    aperture_delay_control #(.CAL_UNIT(4)) u_aperture_delay_control (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cal_measured_delay, .tad_delay, .clock_invert, .irq);
    // ====================
    // checking and bus tasks
    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [13:0] a, input logic [23:0] d);
        q.push_back('{{RESP_OKAY, 32'h0}, ALL});
        s_axi_awaddr <= a;
        s_axi_wdata <= {8'h00, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] a, input logic [33:0] e, input logic [33:0] m);
        q.push_back('{e, m});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    // three steps take between two and three prescaler periods
    task automatic ramp(input logic [7:0] tg);
        n = 0;
        while (tad_delay[15:8] !== tg && n < 1200) begin
            @(posedge aclk);
            n++;
        end
        chk("ramp", 34'(n >= 512 && n <= 776), 34'h1);
    endtask
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            nt = q.pop_front();
            chk("bresp", {s_axi_bresp, 32'h0} & nt.m, nt.e);
        end
        if (s_axi_rvalid && s_axi_rready) begin
            nt = q.pop_front();
            chk("rdata", {s_axi_rresp, s_axi_rdata} & nt.m, nt.e);
        end
    end
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        #(40 * 20000);
        n_fail++;
        test_done();
    end
    // ====================
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cal_measured_delay} = 77'h0;
        s_axi_wstrb = 4'hF;
        seed = 47;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(A_DLY, 34'h0, ALL);
        rd(A_RMP, 34'h0, ALL);
        rd(A_CFG, {26'h0, CAL_CONFIG_RESET}, ALL);
        rd(14'h3FC, {RESP_SLVERR, 32'h0}, ALL);
        chk("tad", {17'h0, tad_delay}, 34'h0);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            v = 24'($random(seed));
            wr(A_DLY, v);
            repeat (4) @(posedge aclk);
            chk("tad", {17'h0, tad_delay}, {17'h0, v[16:0]});
            chk("inv", {33'h0, clock_invert}, {33'h0, v[16]});
            rd(A_DLY, {10'h0, v}, ALL);
        end
        t = 8'($random(seed));
        wr(A_DLY, {8'h00, t, 8'h00});
        wr(A_DLY, {8'h00, t + 8'h01, 8'h00});
        repeat (4) @(posedge aclk);
        chk("step", {26'h0, tad_delay[15:8]}, {26'h0, t + 8'h01});
        $display("test manual done");
        wr(A_DLY, 24'h00405A);
        wr(A_IM, 24'h000002);
        wr(A_RMP, 24'h000001);
        wr(A_DLY, 24'h00435A);
        ramp(8'h43);
        repeat (2) @(posedge aclk);
        chk("irq", {33'h0, irq}, 34'h1);
        rd(A_IS, 34'h2, 34'h3);
        wr(A_RMP, 24'h000003);
        wr(A_DLY, 24'h00395A);
        ramp(8'h39);
        chk("fine", {26'h0, tad_delay[7:0]}, 34'h5A);
        $display("test ramp done");
        cal_measured_delay <= 17'($random(seed));
        wr(A_RMP, 24'h000000);
        wr(A_IM, 24'h000001);
        wr(A_CFG, 24'h000000);
        wr(A_EN, 24'h000001);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        chk("cal irq", {33'h0, irq}, 34'h1);
        rd(A_ST, {17'h00001, cal_measured_delay}, ALL);
        chk("cal", {17'h0, tad_delay}, {17'h0, cal_measured_delay});
        wr(A_DLY, 24'h012345);
        repeat (4) @(posedge aclk);
        chk("cal", {17'h0, tad_delay}, {17'h0, cal_measured_delay});
        rd(A_IS, 34'h3, 34'h3);
        wr(A_EN, 24'h000000);
        repeat (4) @(posedge aclk);
        rd(A_ST, 34'h0, 34'h20000);
        chk("tad", {17'h0, tad_delay}, 34'h12345);
        $display("test calibration done");
        test_done();
    end
endmodule // tb
